// File: rtl/rcb_pkg.sv
// package for the reset, clock-ratio and boot-strap control block
// assumes a single reference clock domain and an active-low asynchronous reset
package rcb_pkg;

    // ------------------------------------------------------------------
    // strap encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] RATIO_CODE_6 = 2'h0;
    localparam logic [1:0] RATIO_CODE_32 = 2'h1;
    localparam logic [1:0] RATIO_CODE_16 = 2'h2;
    localparam logic [1:0] RATIO_CODE_RSV = 2'h3;
    localparam logic [1:0] BOOT_CODE_SPI_SLAVE = 2'h0;
    localparam logic [1:0] BOOT_CODE_SPI_MASTER = 2'h1;
    localparam logic [1:0] BOOT_CODE_EPROM = 2'h2;
    localparam logic [1:0] BOOT_CODE_RSV = 2'h3;

    // ------------------------------------------------------------------
    // ratios, widths, reset values
    // ------------------------------------------------------------------
    localparam int MULT_W = 6;
    localparam int DIV_W = 4;
    localparam logic [5:0] RATIO_6 = 6'h06;
    localparam logic [5:0] RATIO_32 = 6'h20;
    localparam logic [5:0] RATIO_16 = 6'h10;
    localparam logic [3:0] DIV_RESET = 4'h1;
    localparam int PMC_W = 16;
    localparam int PMC_LOCAL_CLOCK_OUTPUT_SEL_BIT = 12;
    localparam int PMC_MULT_LSB = 0;
    localparam int PMC_DIV_LSB = 6;
    localparam int PMC_BYPASS_BIT = 10;
    localparam logic [15:0] PMC_RESET = 16'h0000;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int LOCK_WAIT_CYCLES = 4096;
    localparam int LOCK_CNT_W = 13;
    localparam logic [31:0] RESET_VECTOR = 32'h0009_0000;

    typedef enum logic [1:0] {
        BOOT_SPI_SLAVE,
        BOOT_SPI_MASTER,
        BOOT_EPROM,
        BOOT_NONE
    } rcb_boot_t;

    typedef struct packed {
        logic [MULT_W-1:0] mult;
        logic [DIV_W-1:0] div;
        logic bypass;
    } rcb_pll_cfg_t;

endpackage : rcb_pkg

// File: rtl/rcb_reset_clock_boot.sv
// reset release, strap capture, pll retune and clock-output select for the processor
// assumes straps and the reset pin are asynchronous to the reference clock,
// and that the reference clock runs continuously
`timescale 1ns/100ps

// Overview of operation
// - strap code 00, 01, 10 on the ratio pins gives a start-up ratio of 6, 32 and 16.
// - the core clock comes from the pll or straight from the input clock as the ratio straps decide, until software writes power-mode bit 10.
// - once the core runs, software may rewrite pll multiplier and divider at any time.
// - boot straps 00, 01, 10 pick spi slave, spi master and eprom boot over the async memory interface.
// - after reset release the core waits 4096 input-clock cycles for pll lock.
// - after the wait the core fetches from the hardware reset vector.
// - power-mode bit 12 chooses pll clock or reset-out on the clock-output pin, reset-out by default.
// - the ratio straps are sampled at the third clock after reset is released.
module rcb_reset_clock_boot #(
    parameter int LOCK_WAIT = rcb_pkg::LOCK_WAIT_CYCLES
) (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic I_CE,
    input wire logic [1:0] I_CORE_RATIO_SELECT_CODE,
    input wire logic [1:0] I_BOOT_SELECT_CODE,
    input wire logic I_PMC_WE,
    input wire logic [rcb_pkg::PMC_W-1:0] I_PMC_WDATA,
    input wire logic I_PLL_CLK,
    output logic [rcb_pkg::PMC_W-1:0] O_POWER_MODE_CONTROL_REG,
    output rcb_pkg::rcb_pll_cfg_t O_PLL_CFG,
    output rcb_pkg::rcb_boot_t O_BOOT_MODE,
    output logic O_STRAP_RESERVED,
    output logic O_CORE_RESET_N,
    output logic O_CORE_START,
    output logic [31:0] O_FETCH_ADDR,
    output logic O_LOCAL_CLOCK_OUTPUT
);
    import rcb_pkg::*;

    // ------------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------------
    logic [1:0] ratio_s1;
    logic [1:0] ratio_s2;
    logic [1:0] boot_s1;
    logic [1:0] boot_s2;
    logic rst_s1;
    logic rst_s2;

    // straps are board levels, so two flops before use
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ratio_s1 <= 2'h0;
            ratio_s2 <= 2'h0;
            boot_s1 <= 2'h0;
            boot_s2 <= 2'h0;
        end else if (I_CE) begin
            ratio_s1 <= I_CORE_RATIO_SELECT_CODE;
            ratio_s2 <= ratio_s1;
            boot_s1 <= I_BOOT_SELECT_CODE;
            boot_s2 <= boot_s1;
        end
    end

    // release of reset is synchronised; assertion stays asynchronous
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else if (I_CE) begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end

    // ------------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------------
    logic captured;
    logic [1:0] ratio_code;
    logic [1:0] boot_code;

    // latch once at the first clock after the synchronised release, so the
    // straps seen are those held across reset; later pin changes are ignored
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            captured <= 1'b0;
            ratio_code <= RATIO_CODE_6;
            boot_code <= BOOT_CODE_SPI_SLAVE;
        end else if (I_CE && rst_s2 && !captured) begin
            captured <= 1'b1;
            ratio_code <= ratio_s2;
            boot_code <= boot_s2;
        end
    end

    // ------------------------------------------------------------------
    // lock wait and core start
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_HOLD,
        ST_LOCK_WAIT,
        ST_RUN
    } rcb_state_t;

    rcb_state_t state;
    logic [LOCK_CNT_W-1:0] lock_cnt;
    localparam logic [LOCK_CNT_W-1:0] LOCK_LAST = LOCK_CNT_W'(LOCK_WAIT - 1);

    // count input-clock cycles from capture; reset assertion restarts it all
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state <= ST_HOLD;
            lock_cnt <= '0;
        end else if (I_CE) begin
            case (state)
                ST_HOLD: begin
                    if (captured) begin
                        state <= ST_LOCK_WAIT;
                    end
                end
                ST_LOCK_WAIT: begin
                    if (lock_cnt == LOCK_LAST) begin
                        state <= ST_RUN;
                    end else begin
                        lock_cnt <= lock_cnt + 1'b1;
                    end
                end
                default: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    // one-cycle start strobe and reset-vector fetch address
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_CORE_START <= 1'b0;
            O_CORE_RESET_N <= 1'b0;
            O_FETCH_ADDR <= RESET_VECTOR;
        end else if (I_CE) begin
            O_CORE_START <= (state == ST_LOCK_WAIT) && (lock_cnt == LOCK_LAST);
            O_CORE_RESET_N <= (state == ST_RUN) ||
                              ((state == ST_LOCK_WAIT) && (lock_cnt == LOCK_LAST));
            O_FETCH_ADDR <= RESET_VECTOR;
        end
    end

    // ------------------------------------------------------------------
    // strap decode
    // ------------------------------------------------------------------
    logic [MULT_W-1:0] strap_mult;
    logic strap_bypass;

    // reserved ratio code falls back to bypass so the core still gets a clock
    always_comb begin
        strap_bypass = 1'b0;
        if (ratio_code == RATIO_CODE_6) begin
            strap_mult = RATIO_6;
        end else if (ratio_code == RATIO_CODE_32) begin
            strap_mult = RATIO_32;
        end else if (ratio_code == RATIO_CODE_16) begin
            strap_mult = RATIO_16;
        end else begin
            strap_mult = RATIO_6;
            strap_bypass = 1'b1;
        end
    end

    // boot method from the captured code; reserved code boots nothing
    always_comb begin
        case (boot_code)
            BOOT_CODE_SPI_SLAVE: O_BOOT_MODE = BOOT_SPI_SLAVE;
            BOOT_CODE_SPI_MASTER: O_BOOT_MODE = BOOT_SPI_MASTER;
            BOOT_CODE_EPROM: O_BOOT_MODE = BOOT_EPROM;
            default: O_BOOT_MODE = BOOT_NONE;
        endcase
    end

    assign O_STRAP_RESERVED = captured &&
                              ((ratio_code == RATIO_CODE_RSV) || (boot_code == BOOT_CODE_RSV));

    // ------------------------------------------------------------------
    // power-mode control register
    // ------------------------------------------------------------------
    logic sw_written;

    // writes are only honoured once the core runs; before that the straps rule
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_POWER_MODE_CONTROL_REG <= PMC_RESET;
            sw_written <= 1'b0;
        end else if (I_CE) begin
            if (I_PMC_WE && (state == ST_RUN)) begin
                O_POWER_MODE_CONTROL_REG <= I_PMC_WDATA;
                sw_written <= 1'b1;
            end
        end
    end

    // pll settings: strap values until software retunes, then the register
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_PLL_CFG <= '{mult: RATIO_6, div: DIV_RESET, bypass: 1'b0};
        end else if (I_CE) begin
            if (sw_written) begin
                O_PLL_CFG.mult <= O_POWER_MODE_CONTROL_REG[PMC_MULT_LSB +: MULT_W];
                O_PLL_CFG.div <= O_POWER_MODE_CONTROL_REG[PMC_DIV_LSB +: DIV_W];
                O_PLL_CFG.bypass <= O_POWER_MODE_CONTROL_REG[PMC_BYPASS_BIT];
            end else begin
                O_PLL_CFG.mult <= strap_mult;
                O_PLL_CFG.div <= DIV_RESET;
                O_PLL_CFG.bypass <= strap_bypass;
            end
        end
    end

    // ------------------------------------------------------------------
    // clock-output pin
    // ------------------------------------------------------------------
    // the pll clock is muxed in directly; the select is a static register bit,
    // so glitches appear only when a software write or a reset assertion flips it
    assign O_LOCAL_CLOCK_OUTPUT = O_POWER_MODE_CONTROL_REG[PMC_LOCAL_CLOCK_OUTPUT_SEL_BIT] ? I_PLL_CLK
                                                                               : O_CORE_RESET_N;

endmodule : rcb_reset_clock_boot

// File: test/rcb_reset_clock_boot_chk.sv
// assertions on the ports of the reset, strap and clock-output block
// assumes a single reference clock domain and the block's own ports
`timescale 1ns/100ps
module rcb_reset_clock_boot_chk #(
    parameter int LOCK_WAIT = rcb_pkg::LOCK_WAIT_CYCLES
) (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic I_CE,
    input wire logic [1:0] I_CORE_RATIO_SELECT_CODE,
    input wire logic [1:0] I_BOOT_SELECT_CODE,
    input wire logic I_PMC_WE,
    input wire logic [15:0] I_PMC_WDATA,
    input wire logic I_PLL_CLK,
    input wire logic [15:0] O_POWER_MODE_CONTROL_REG,
    input wire rcb_pkg::rcb_pll_cfg_t O_PLL_CFG,
    input wire rcb_pkg::rcb_boot_t O_BOOT_MODE,
    input wire logic O_STRAP_RESERVED,
    input wire logic O_CORE_RESET_N,
    input wire logic O_CORE_START,
    input wire logic [31:0] O_FETCH_ADDR,
    input wire logic O_LOCAL_CLOCK_OUTPUT
);
    import rcb_pkg::*;
    int cnt;
    // enabled cycles while the core is held in reset; saturates so it never wraps
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            cnt <= 0;
        end else if (I_CE && !O_CORE_RESET_N && cnt < 65535) begin
            cnt <= cnt + 1;
        end
    end
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_N);
    a_lock_wait_len: assert property ($rose(O_CORE_RESET_N) |-> cnt >= LOCK_WAIT)
        else $error("core left reset before the lock wait ended");
    a_start_at_release: assert property ($rose(O_CORE_RESET_N) |-> O_CORE_START)
        else $error("no start pulse at core release");
    a_start_one_cycle: assert property (O_CORE_START |=> !O_CORE_START)
        else $error("start pulse longer than one cycle");
    a_fetch_vector: assert property (O_CORE_START |-> O_FETCH_ADDR == RESET_VECTOR)
        else $error("fetch address is not the reset vector");
    a_local_clock_output_reset: assert property (!O_POWER_MODE_CONTROL_REG[12] |-> O_LOCAL_CLOCK_OUTPUT == O_CORE_RESET_N)
        else $error("clock output does not show reset-out");
    a_local_clock_output_pll: assert property (O_POWER_MODE_CONTROL_REG[12] |-> O_LOCAL_CLOCK_OUTPUT == I_PLL_CLK)
        else $error("clock output does not follow the pll clock");
    a_write_taken: assert property (I_CE && I_PMC_WE && O_CORE_RESET_N |=> O_POWER_MODE_CONTROL_REG == $past(I_PMC_WDATA))
        else $error("register write lost");
    a_pll_retune: assert property (I_CE && I_PMC_WE && O_CORE_RESET_N |-> ##2
        O_PLL_CFG == {$past(I_PMC_WDATA[5:0], 2), $past(I_PMC_WDATA[9:6], 2), $past(I_PMC_WDATA[10], 2)})
        else $error("pll settings do not follow the write");
    a_write_refused: assert property (!O_CORE_RESET_N |-> O_POWER_MODE_CONTROL_REG == 16'h0000)
        else $error("register changed before the core ran");
    a_boot_held: assert property (O_CORE_RESET_N && $past(O_CORE_RESET_N) |-> $stable(O_BOOT_MODE))
        else $error("boot mode changed while running");
    c_release: cover property ($rose(O_CORE_RESET_N));
    c_write: cover property (I_PMC_WE && O_CORE_RESET_N);
    c_pll_out: cover property (O_POWER_MODE_CONTROL_REG[12] && O_LOCAL_CLOCK_OUTPUT);
endmodule : rcb_reset_clock_boot_chk

bind rcb_reset_clock_boot rcb_reset_clock_boot_chk #(.LOCK_WAIT(LOCK_WAIT)) chk_u (.*);

// File: test/rcb_board_model.sv
// board model: reset source, strap pins and a free-running pll clock
// assumes the bench requests reset and straps, sampled at falling edges
`timescale 1ns/100ps
module rcb_board_model (
    input wire logic i_clk,
    input wire logic i_rst_req,
    input wire logic [1:0] i_ratio,
    input wire logic [1:0] i_boot,
    output logic o_rst_n,
    output logic [1:0] o_ratio,
    output logic [1:0] o_boot,
    output logic o_pll_clk
);
    logic req_d;
    // reset is low from power-up on
    initial begin
        o_rst_n = 1'b0;
        req_d = 1'b1;
        o_pll_clk = 1'b0;
        o_ratio = 2'h0;
        o_boot = 2'h0;
    end
    // straps move one cycle ahead of the reset edge, so they are valid first
    always @(negedge i_clk) begin
        o_ratio <= i_ratio;
        o_boot <= i_boot;
        req_d <= i_rst_req;
        o_rst_n <= !req_d;
    end
    // pll clock runs off the 1 ns grid, so it never toggles on a reference clock edge
    initial begin
        #0.1;
        forever #5 o_pll_clk = ~o_pll_clk;
    end
endmodule : rcb_board_model

// File: test/rcb_reset_clock_boot_bench.sv
// self-checking bench for the reset, strap and clock-output block
// assumes the board model owns reset and straps; other inputs change at falling edges
`timescale 1ns/100ps
module rcb_reset_clock_boot_bench;
    import rcb_pkg::*;
    localparam int LW = 8;
    logic clk = 1'b0;
    logic rst_req = 1'b1;
    logic ce = 1'b1;
    logic we = 1'b0;
    logic [15:0] wdata = 16'h0000;
    logic [1:0] ratio = 2'h0;
    logic [1:0] boot = 2'h0;
    logic rst_n, pll_clk, rsv, core_rst_n, start, local_clock_output;
    logic [1:0] s_ratio, s_boot;
    logic [15:0] pmc;
    logic [31:0] fetch;
    rcb_pll_cfg_t cfg;
    rcb_boot_t mode;
    logic [5:0] exp_mult [4] = '{RATIO_6, RATIO_32, RATIO_16, RATIO_6};
    rcb_boot_t exp_boot [4] = '{BOOT_SPI_SLAVE, BOOT_SPI_MASTER, BOOT_EPROM, BOOT_NONE};
    int n_fail = 0;
    int n_compared = 0;
    int k;
    // reference clock never pauses
    always #25 clk = ~clk;
    rcb_board_model board_u (.i_clk(clk), .i_rst_req(rst_req), .i_ratio(ratio), .i_boot(boot),
        .o_rst_n(rst_n), .o_ratio(s_ratio), .o_boot(s_boot), .o_pll_clk(pll_clk));
    rcb_reset_clock_boot #(.LOCK_WAIT(LW)) dut_u (.I_CLK(clk), .I_RST_N(rst_n), .I_CE(ce),
        .I_CORE_RATIO_SELECT_CODE(s_ratio), .I_BOOT_SELECT_CODE(s_boot), .I_PMC_WE(we),
        .I_PMC_WDATA(wdata), .I_PLL_CLK(pll_clk), .O_POWER_MODE_CONTROL_REG(pmc), .O_PLL_CFG(cfg),
        .O_BOOT_MODE(mode), .O_STRAP_RESERVED(rsv), .O_CORE_RESET_N(core_rst_n),
        .O_CORE_START(start), .O_FETCH_ADDR(fetch), .O_LOCAL_CLOCK_OUTPUT(local_clock_output));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic stop_test();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test
    // strapped reset; ce low for frz edges stretches the wait, and an early write must be dropped
    task automatic strap_reset(input logic [1:0] r, input logic [1:0] b, input int frz);
        @(negedge clk);
        ratio <= r;
        boot <= b;
        rst_req <= 1'b1;
        repeat (16) @(negedge clk);
        rst_req <= 1'b0;
        repeat (2) @(negedge clk);
        ce <= (frz == 0);
        k = 0;
        while (core_rst_n !== 1'b1 && k < 200) begin
            @(negedge clk);
            k++;
            ce <= (k >= frz);
            we <= (k == 6);
            wdata <= 16'hffff;
        end
        if (k >= 200) begin
            n_fail++;
            stop_test();
        end else begin
            chk(k, LW + 4 + frz);
            chk(start, 1'b1);
            chk(fetch, RESET_VECTOR);
            chk(pmc, 16'h0000);
            chk(local_clock_output, 1'b1);
        end
    endtask : strap_reset
    // two back-to-back writes; the second must win
    task automatic pmc_write(input logic [15:0] a, input logic [15:0] b, input rcb_pll_cfg_t exp);
        @(negedge clk);
        we <= 1'b1;
        wdata <= a;
        @(negedge clk);
        wdata <= b;
        @(negedge clk);
        we <= 1'b0;
        chk(pmc, b);
        @(negedge clk);
        chk(cfg, exp);
        chk(local_clock_output, b[12] ? pll_clk : 1'b1);
    endtask : pmc_write
    initial begin
        for (int i = 0; i < 4; i++) begin
            strap_reset(2'(i), 2'(i), (i == 3) ? 5 : 0);
            chk(cfg.mult, exp_mult[i]);
            chk(cfg.div, DIV_RESET);
            chk(cfg.bypass, i == 3);
            chk(mode, exp_boot[i]);
            chk(rsv, i == 3);
        end
        // straps moved while running are ignored
        ratio <= 2'h2;
        boot <= 2'h1;
        repeat (4) @(negedge clk);
        chk(mode, BOOT_NONE);
        chk(cfg.bypass, 1'b1);
        pmc_write(16'h1000, 16'h1283, rcb_pll_cfg_t'{6'h03, 4'ha, 1'b0});
        pmc_write(16'h1fff, 16'h0406, rcb_pll_cfg_t'{6'h06, 4'h0, 1'b1});
        strap_reset(2'h2, 2'h2, 0);
        stop_test();
    end
endmodule : rcb_reset_clock_boot_bench
